//--- shared/lrc_pkg.sv
// lrc_pkg: constants and types of the lan reset control
// assumes one 250 MHz device clock and a 32-bit AXI4-Lite bus
package lrc_pkg;
  localparam int LRC_NF = 2; // lan functions
  localparam int LRC_FSEL_LSB = 16; // function window
  localparam int LRC_FSEL_W = 1;
  // register offsets
  localparam logic [15:0] LRC_OFF_CTRL = 16'h0000;
  localparam logic [15:0] LRC_OFF_EXT = 16'h0018;
  localparam logic [15:0] LRC_OFF_STAT = 16'h0040;
  localparam logic [15:0] LRC_OFF_MCFG = 16'h0044;
  localparam logic [15:0] LRC_OFF_CFGST = 16'h1010;
  localparam logic [15:0] LRC_OFF_SEM = 16'h5b50;
  localparam logic [15:0] LRC_OFF_HOST_IF_CONTROL = 16'h8f00;
  typedef enum logic [2:0] {
    LRC_R_NONE, LRC_R_CTRL, LRC_R_EXT, LRC_R_STAT,
    LRC_R_MCFG, LRC_R_CFGST, LRC_R_SEM, LRC_R_HOST_IF_CONTROL
  } lrc_reg_t;
  // field positions
  localparam int LRC_CTRL_DEV_RST = 0;
  localparam int LRC_CTRL_LINK_RST = 1;
  localparam int LRC_CTRL_PHY_RST = 31;
  localparam int LRC_EXT_NVM_RELOAD = 0;
  localparam int LRC_CFG_FIELD_W = 16;
  localparam int LRC_CFG_BUSY = 16;
  localparam int LRC_CFG_DONE = 18;
  localparam int LRC_SEM_SW = 0;
  localparam int LRC_HOST_IF_CONTROL_FW = 0;
  localparam int LRC_STAT_HOST_IO = 0;
  localparam int LRC_STAT_DISABLE = 1;
  localparam int LRC_STAT_CHIP = 2;
  localparam int LRC_STAT_FUNC_LSB = 8;
  localparam int LRC_STAT_PEND_LSB = 16;
  localparam int LRC_STAT_AN_LSB = 24;
  localparam int LRC_MCFG_EN = 0;
  localparam int LRC_MCFG_ROF = 1;
  localparam int LRC_MCFG_PT = 2;
  localparam int LRC_MCFG_FEN_LSB = 8;
  localparam logic [15:0] LRC_NVM_DEFAULT = 16'h0000;
  localparam logic [1:0] LRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LRC_RESP_SLVERR = 2'h2;
  // timing
  localparam int LRC_CLK_NS = 4;
  localparam int LRC_RST_PULSE_NS = 64;
  localparam int LRC_RST_PULSE_CYC = (LRC_RST_PULSE_NS + LRC_CLK_NS - 1) / LRC_CLK_NS;
  localparam int LRC_NVM_LOAD_NS = 2000;
  localparam int LRC_NVM_LOAD_CYC = (LRC_NVM_LOAD_NS + LRC_CLK_NS - 1) / LRC_CLK_NS;
  localparam int LRC_CNT_W = 10;
  // link control towards the tbi logic
  typedef struct packed {
    logic [LRC_NF-1:0] link_rst;
    logic [LRC_NF-1:0] send_cfg;
    logic [LRC_NF-1:0] an_en;
    logic [LRC_NF-1:0] an_restart;
  } lrc_tbi_t;
  // whole state of the block
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic hpw_prev;
    logic ldn_prev;
    logic chip_rst;
    logic [LRC_CNT_W-1:0] chip_cnt;
    logic host_io_rst;
    logic dev_dis;
    logic fw_rst;
    logic [LRC_CNT_W-1:0] fw_cnt;
    logic sem;
    logic mgmt_en;
    logic rof;
    logic pt;
    logic [LRC_NF-1:0] fen;
    logic [LRC_NF-1:0] func_rst;
    logic [LRC_NF-1:0][LRC_CNT_W-1:0] func_cnt;
    logic [LRC_NF-1:0] lrst;
    logic [LRC_NF-1:0] phy_rst;
    logic [LRC_NF-1:0] pend;
    logic [LRC_NF-1:0] nvm_busy;
    logic [LRC_NF-1:0] nvm_ok;
    logic [LRC_NF-1:0][LRC_CNT_W-1:0] nvm_cnt;
    logic [LRC_NF-1:0][15:0] nvm_field;
    lrc_tbi_t tbi;
  } lrc_state_t;
endpackage : lrc_pkg

//--- core/lrc_reset_control.sv
// lrc_reset_control: reset sources, scoping and phy reset handshake
// assumes all inputs synchronous to MCLK, AXI4-Lite master outside
`timescale 1ns/1ns
`default_nettype none
module lrc_reset_control #(
  parameter bit MULTI_PORT = 1'b1, // forced reset per function
  parameter bit USE_PERST = 1'b0, // PERST_N replaces host power
  parameter int RST_PULSE_CYC = lrc_pkg::LRC_RST_PULSE_CYC,
  parameter int NVM_LOAD_CYC = lrc_pkg::LRC_NVM_LOAD_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // power and pcie reset sources
  input wire logic MAIN_POWER_OK,
  input wire logic HOST_POWER_OK,
  input wire logic PERST_N,
  input wire logic D3COLD_EXIT,
  input wire logic PCIE_RESET_MSG,
  input wire logic PCIE_LINK_DOWN,
  input wire logic [lrc_pkg::LRC_NF-1:0] D3HOT_TO_D0,
  input wire logic DEVICE_OFF_N,
  input wire logic SHUTDOWN,
  // management subsystem
  input wire logic MGMT_CMD_VALID,
  input wire logic [7:0] MGMT_CMD_DATA,
  input wire logic [lrc_pkg::LRC_FSEL_W-1:0] MGMT_TARGET,
  input wire logic ASF_WDOG_EXPIRE,
  input wire logic ASF_FORCE_REQ,
  input wire logic [lrc_pkg::LRC_NF-1:0] MGMT_PHY_CFG_ACK,
  // nvm image and link mode
  input wire logic [lrc_pkg::LRC_NF-1:0][15:0] NVM_WORD,
  input wire logic TBI_MODE,
  // reset outputs
  output logic CHIP_RST,
  output logic HOST_IO_RST,
  output logic [lrc_pkg::LRC_NF-1:0] FUNC_RST,
  output logic [lrc_pkg::LRC_NF-1:0] PHY_RST,
  output logic FW_RST,
  output logic DEVICE_DISABLE,
  output logic [lrc_pkg::LRC_NF-1:0] MGMT_PHY_RECONFIG_REQ,
  output lrc_pkg::lrc_tbi_t TBI_CTRL,
  // axi4-lite write
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);
  localparam int NF = lrc_pkg::LRC_NF;
  localparam int CW = lrc_pkg::LRC_CNT_W;
  localparam int FLSB = lrc_pkg::LRC_FSEL_LSB;
  localparam int HI = lrc_pkg::LRC_FSEL_LSB + lrc_pkg::LRC_FSEL_W;
  localparam logic [CW-1:0] PULSE_M1 = CW'(RST_PULSE_CYC - 1);
  localparam logic [CW-1:0] LOAD_M1 = CW'(NVM_LOAD_CYC - 1);

  lrc_pkg::lrc_state_t s_q; // registered state
  lrc_pkg::lrc_state_t s_d; // next state
  lrc_pkg::lrc_reg_t wr_id; // decoded write target
  lrc_pkg::lrc_reg_t rd_id; // decoded read target
  logic [lrc_pkg::LRC_FSEL_W-1:0] wr_f; // write function
  logic [lrc_pkg::LRC_FSEL_W-1:0] rd_f; // read function
  logic wr_fire; // both halves of a write held
  logic host_pwr; // selected host power level
  logic [31:0] rd_data; // read mux result

  // map an address onto a register; upper bits must be zero
  function automatic lrc_pkg::lrc_reg_t decode(input logic [31:0] a);
    decode = lrc_pkg::LRC_R_NONE;
    if (a[31:HI] == '0) begin
      case (a[15:0])
        lrc_pkg::LRC_OFF_CTRL: decode = lrc_pkg::LRC_R_CTRL;
        lrc_pkg::LRC_OFF_EXT: decode = lrc_pkg::LRC_R_EXT;
        lrc_pkg::LRC_OFF_STAT: decode = lrc_pkg::LRC_R_STAT;
        lrc_pkg::LRC_OFF_MCFG: decode = lrc_pkg::LRC_R_MCFG;
        lrc_pkg::LRC_OFF_CFGST: decode = lrc_pkg::LRC_R_CFGST;
        lrc_pkg::LRC_OFF_SEM: decode = lrc_pkg::LRC_R_SEM;
        lrc_pkg::LRC_OFF_HOST_IF_CONTROL: decode = lrc_pkg::LRC_R_HOST_IF_CONTROL;
        default: decode = lrc_pkg::LRC_R_NONE;
      endcase
    end
  endfunction : decode

  // one bit under its byte strobe; unstrobed keeps cur
  function automatic logic wbit(input logic cur, input logic [31:0] d,
                                input logic [3:0] st, input int p);
    wbit = st[p / 8] ? d[p] : cur;
  endfunction : wbit

  // decode and source selection
  assign wr_id = decode(s_q.awaddr);
  assign rd_id = decode(S_AXI_ARADDR);
  assign wr_f = s_q.awaddr[FLSB +: lrc_pkg::LRC_FSEL_W];
  assign rd_f = S_AXI_ARADDR[FLSB +: lrc_pkg::LRC_FSEL_W];
  assign wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
  // the PERST variant uses the pin in place of host power
  assign host_pwr = USE_PERST ? PERST_N : HOST_POWER_OK;

  // read mux; reserved bits read zero
  always_comb begin
    rd_data = '0;
    unique case (rd_id)
      lrc_pkg::LRC_R_CTRL: begin
        rd_data[lrc_pkg::LRC_CTRL_PHY_RST] = s_q.phy_rst[rd_f];
        rd_data[lrc_pkg::LRC_CTRL_LINK_RST] = s_q.lrst[rd_f];
        // device reset reads back as reset in progress
        rd_data[lrc_pkg::LRC_CTRL_DEV_RST] = s_q.func_rst[rd_f];
      end
      lrc_pkg::LRC_R_EXT: begin
        rd_data[lrc_pkg::LRC_EXT_NVM_RELOAD] = s_q.nvm_busy[rd_f];
      end
      lrc_pkg::LRC_R_CFGST: begin
        // done only once nvm is loaded and phy reconfigured
        rd_data[lrc_pkg::LRC_CFG_DONE] = s_q.nvm_ok[rd_f] & ~s_q.pend[rd_f];
        rd_data[lrc_pkg::LRC_CFG_BUSY] = s_q.nvm_busy[rd_f];
        rd_data[lrc_pkg::LRC_CFG_FIELD_W-1:0] = s_q.nvm_field[rd_f];
      end
      lrc_pkg::LRC_R_SEM: begin
        rd_data[lrc_pkg::LRC_SEM_SW] = s_q.sem;
      end
      lrc_pkg::LRC_R_HOST_IF_CONTROL: begin
        rd_data[lrc_pkg::LRC_HOST_IF_CONTROL_FW] = s_q.fw_rst;
      end
      lrc_pkg::LRC_R_STAT: begin
        rd_data[lrc_pkg::LRC_STAT_HOST_IO] = s_q.host_io_rst;
        rd_data[lrc_pkg::LRC_STAT_DISABLE] = s_q.dev_dis;
        rd_data[lrc_pkg::LRC_STAT_CHIP] = s_q.chip_rst;
        rd_data[lrc_pkg::LRC_STAT_FUNC_LSB +: NF] = s_q.func_rst;
        rd_data[lrc_pkg::LRC_STAT_PEND_LSB +: NF] = s_q.pend;
        rd_data[lrc_pkg::LRC_STAT_AN_LSB +: NF] = s_q.tbi.an_en;
      end
      lrc_pkg::LRC_R_MCFG: begin
        rd_data[lrc_pkg::LRC_MCFG_EN] = s_q.mgmt_en;
        rd_data[lrc_pkg::LRC_MCFG_ROF] = s_q.rof;
        rd_data[lrc_pkg::LRC_MCFG_PT] = s_q.pt;
        rd_data[lrc_pkg::LRC_MCFG_FEN_LSB +: NF] = s_q.fen;
      end
      lrc_pkg::LRC_R_NONE: begin
        rd_data = '0;
      end
    endcase
  end

  // next state
  always_comb begin
    logic chip_go; // chip-wide reset request
    logic fmr; // forced management reset request
    logic [NF-1:0] func_go; // per-function reset request
    logic [NF-1:0] nvm_go; // per-function reload request
    chip_go = 1'b0;
    fmr = 1'b0;
    func_go = '0;
    nvm_go = '0;
    s_d = s_q;

    // chip-wide causes merge into one pulse
    chip_go = (host_pwr & ~s_q.hpw_prev)
            | D3COLD_EXIT
            | PCIE_RESET_MSG
            | (PCIE_LINK_DOWN & ~s_q.ldn_prev);
    // forced reset only with mgmt on and the flag set
    if (s_q.mgmt_en & s_q.rof) begin
      if (s_q.pt) begin
        fmr = MGMT_CMD_VALID & MGMT_CMD_DATA[0];
      end else begin
        fmr = ASF_WDOG_EXPIRE | ASF_FORCE_REQ;
      end
    end
    // single port: forced reset is chip-wide
    if (!MULTI_PORT) begin
      chip_go = chip_go | fmr;
    end
    func_go = {NF{chip_go}} | D3HOT_TO_D0;
    // multi-port: only the targeted, enabled function
    for (int f = 0; f < NF; f++) begin
      if (MULTI_PORT && fmr && s_q.fen[f] && (int'(MGMT_TARGET) == f)) begin
        func_go[f] = 1'b1;
      end
    end

    // edge history and level-held resets
    s_d.hpw_prev = host_pwr;
    s_d.ldn_prev = PCIE_LINK_DOWN;
    s_d.host_io_rst = ~host_pwr;
    s_d.dev_dis = ~DEVICE_OFF_N & ~SHUTDOWN;

    // firmware reset pulse stretch
    if (s_q.fw_rst) begin
      if (s_q.fw_cnt == '0) begin
        s_d.fw_rst = 1'b0;
      end else begin
        s_d.fw_cnt = s_q.fw_cnt - 1'b1;
      end
    end

    // write address and data, taken in either order
    if (S_AXI_AWVALID & s_q.awrdy) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & s_q.wrdy) begin
      s_d.w_got = 1'b1;
      s_d.wdata = S_AXI_WDATA;
      s_d.wstrb = S_AXI_WSTRB;
    end
    if (s_q.bvalid & S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (wr_fire) begin
      s_d.bvalid = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bresp = (wr_id == lrc_pkg::LRC_R_NONE) ? lrc_pkg::LRC_RESP_SLVERR : lrc_pkg::LRC_RESP_OKAY;
      unique case (wr_id)
        lrc_pkg::LRC_R_CTRL: begin
          s_d.phy_rst[wr_f] = wbit(s_q.phy_rst[wr_f], s_q.wdata, s_q.wstrb,
                                   lrc_pkg::LRC_CTRL_PHY_RST);
          s_d.lrst[wr_f] = wbit(s_q.lrst[wr_f], s_q.wdata, s_q.wstrb,
                                lrc_pkg::LRC_CTRL_LINK_RST);
          // device reset is a write-one strobe, addressed function only
          if (wbit(1'b0, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_CTRL_DEV_RST)) begin
            func_go[wr_f] = 1'b1;
          end
        end
        lrc_pkg::LRC_R_EXT: begin
          nvm_go[wr_f] = wbit(1'b0, s_q.wdata, s_q.wstrb,
                              lrc_pkg::LRC_EXT_NVM_RELOAD);
        end
        lrc_pkg::LRC_R_SEM: begin
          s_d.sem = wbit(s_q.sem, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_SEM_SW);
        end
        lrc_pkg::LRC_R_HOST_IF_CONTROL: begin
          if (wbit(1'b0, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_HOST_IF_CONTROL_FW)) begin
            s_d.fw_rst = 1'b1;
            s_d.fw_cnt = PULSE_M1;
          end
        end
        lrc_pkg::LRC_R_MCFG: begin
          s_d.mgmt_en = wbit(s_q.mgmt_en, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_MCFG_EN);
          s_d.rof = wbit(s_q.rof, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_MCFG_ROF);
          s_d.pt = wbit(s_q.pt, s_q.wdata, s_q.wstrb, lrc_pkg::LRC_MCFG_PT);
          for (int f = 0; f < NF; f++) begin
            s_d.fen[f] = wbit(s_q.fen[f], s_q.wdata, s_q.wstrb,
                              lrc_pkg::LRC_MCFG_FEN_LSB + f);
          end
        end
        lrc_pkg::LRC_R_CFGST, lrc_pkg::LRC_R_STAT, lrc_pkg::LRC_R_NONE: begin
          // read-only or unmapped: nothing stored
          s_d.bvalid = 1'b1;
        end
      endcase
    end

    // read: data captured at the address handshake
    if (s_q.rvalid & S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID & s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_data;
      s_d.rresp = (rd_id == lrc_pkg::LRC_R_NONE) ? lrc_pkg::LRC_RESP_SLVERR : lrc_pkg::LRC_RESP_OKAY;
    end

    // chip reset stretch; a new cause restarts it
    if (s_q.chip_rst) begin
      if (s_q.chip_cnt == '0) begin
        s_d.chip_rst = 1'b0;
      end else begin
        s_d.chip_cnt = s_q.chip_cnt - 1'b1;
      end
    end
    if (chip_go) begin
      s_d.chip_rst = 1'b1;
      s_d.chip_cnt = PULSE_M1;
      s_d.sem = 1'b0;
    end

    // per-function reset, nvm load, phy and link
    for (int f = 0; f < NF; f++) begin
      // reset pulse, then the nvm load follows it
      if (s_q.func_rst[f]) begin
        if (s_q.func_cnt[f] == '0) begin
          s_d.func_rst[f] = 1'b0;
          s_d.nvm_busy[f] = 1'b1;
          s_d.nvm_cnt[f] = LOAD_M1;
        end else begin
          s_d.func_cnt[f] = s_q.func_cnt[f] - 1'b1;
        end
      end else if (s_q.nvm_busy[f]) begin
        if (s_q.nvm_cnt[f] == '0) begin
          s_d.nvm_busy[f] = 1'b0;
          s_d.nvm_ok[f] = 1'b1;
          s_d.nvm_field[f] = NVM_WORD[f];
        end else begin
          s_d.nvm_cnt[f] = s_q.nvm_cnt[f] - 1'b1;
        end
      end
      // reload alone keeps the function running
      if (nvm_go[f] & ~s_q.func_rst[f]) begin
        s_d.nvm_busy[f] = 1'b1;
        s_d.nvm_cnt[f] = LOAD_M1;
        s_d.nvm_ok[f] = 1'b0;
      end
      // function reset: own fields only; bus decode, mgmt
      // setup and semaphore are left alone
      if (func_go[f]) begin
        s_d.func_rst[f] = 1'b1;
        s_d.func_cnt[f] = PULSE_M1;
        s_d.lrst[f] = 1'b0;
        s_d.phy_rst[f] = 1'b0;
        s_d.nvm_busy[f] = 1'b0;
        s_d.nvm_ok[f] = 1'b0;
        s_d.nvm_field[f] = lrc_pkg::LRC_NVM_DEFAULT;
      end
      // reconfig pending from phy reset until acked;
      // assertion wins over an ack in the same cycle
      s_d.pend[f] = s_q.phy_rst[f] | (s_q.pend[f] & ~MGMT_PHY_CFG_ACK[f]);
      // link reset acts in tbi mode only
      s_d.tbi.link_rst[f] = TBI_MODE & s_d.lrst[f];
      s_d.tbi.send_cfg[f] = TBI_MODE & s_d.lrst[f];
      s_d.tbi.an_en[f] = TBI_MODE & ~s_d.lrst[f];
      s_d.tbi.an_restart[f] = TBI_MODE & s_q.lrst[f] & ~s_d.lrst[f];
    end

    // readies reopen once the slot is free
    s_d.awrdy = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wrdy = ~s_d.w_got & ~s_d.bvalid;
    s_d.arrdy = ~s_d.rvalid;
  end

  // state register; low main power acts like reset
  always_ff @(posedge MCLK) begin
    if (SRST | ~MAIN_POWER_OK) begin
      s_q <= '0;
      // resets stretch past release, then nvm loads
      s_q.chip_rst <= 1'b1;
      s_q.chip_cnt <= PULSE_M1;
      s_q.func_rst <= '1;
      s_q.func_cnt <= {NF{PULSE_M1}};
      s_q.host_io_rst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign CHIP_RST = s_q.chip_rst;
  assign HOST_IO_RST = s_q.host_io_rst;
  assign FUNC_RST = s_q.func_rst;
  assign PHY_RST = s_q.phy_rst;
  assign FW_RST = s_q.fw_rst;
  assign DEVICE_DISABLE = s_q.dev_dis;
  assign MGMT_PHY_RECONFIG_REQ = s_q.pend;
  assign TBI_CTRL = s_q.tbi;
  assign S_AXI_AWREADY = s_q.awrdy;
  assign S_AXI_WREADY = s_q.wrdy;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arrdy;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;
endmodule : lrc_reset_control
`default_nettype wire

//--- bench/lrc_reset_control_props.sv
// lrc_reset_control_props: port checks of the reset block
// assumes a bind onto the reset block, one clock
`timescale 1ns/1ns
`default_nettype none
module lrc_reset_control_props #(
  parameter int RST_PULSE_CYC = 2
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // reset sources
  input wire logic MAIN_POWER_OK,
  input wire logic HOST_POWER_OK,
  input wire logic D3COLD_EXIT,
  input wire logic PCIE_RESET_MSG,
  input wire logic PCIE_LINK_DOWN,
  input wire logic [lrc_pkg::LRC_NF-1:0] D3HOT_TO_D0,
  input wire logic DEVICE_OFF_N,
  input wire logic SHUTDOWN,
  // reset outputs
  input wire logic CHIP_RST,
  input wire logic HOST_IO_RST,
  input wire logic [lrc_pkg::LRC_NF-1:0] FUNC_RST,
  input wire logic [lrc_pkg::LRC_NF-1:0] PHY_RST,
  input wire logic FW_RST,
  input wire logic DEVICE_DISABLE,
  input wire logic [lrc_pkg::LRC_NF-1:0] MGMT_PHY_RECONFIG_REQ,
  input wire lrc_pkg::lrc_tbi_t TBI_CTRL
);
  // firmware pulse length
  logic [15:0] fw_len_q;
  always_ff @(posedge MCLK) begin
    fw_len_q <= (SRST || !MAIN_POWER_OK || !FW_RST) ? 16'h0 : fw_len_q + 16'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST || !MAIN_POWER_OK);
  a_main_pwr_hold:
    assert property (disable iff (SRST) !MAIN_POWER_OK |=> CHIP_RST && HOST_IO_RST && (&FUNC_RST) && PHY_RST == '0)
    else $error("main power low without full reset");
  a_host_io_hold:
    assert property (!HOST_POWER_OK |=> HOST_IO_RST) else $error("host io unit released early");
  a_chip_cause:
    assert property (D3COLD_EXIT || PCIE_RESET_MSG || $rose(PCIE_LINK_DOWN) |=> CHIP_RST && (&FUNC_RST))
    else $error("chip cause without chip reset");
  a_dev_disable:
    assert property (1'b1 |=> DEVICE_DISABLE == $past(!DEVICE_OFF_N && !SHUTDOWN))
    else $error("device disable wrong");
  a_d3hot_func:
    assert property (D3HOT_TO_D0[0] |=> FUNC_RST[0]) else $error("power state exit missed");
  a_phy_reconf_req:
    assert property ($rose(PHY_RST[0]) |=> MGMT_PHY_RECONFIG_REQ[0]) else $error("no reconfigure request");
  a_tbi_link_hold:
    assert property (TBI_CTRL.link_rst[0] |-> TBI_CTRL.send_cfg[0] && !TBI_CTRL.an_en[0])
    else $error("link reset state wrong");
  a_fw_pulse_len:
    assert property ($fell(FW_RST) |-> fw_len_q == RST_PULSE_CYC) else $error("firmware pulse length");
  c_fw_pulse: cover property ($rose(FW_RST));
  c_an_restart: cover property (TBI_CTRL.an_restart[0]);
  c_reconf_done: cover property ($fell(MGMT_PHY_RECONFIG_REQ[0]));
endmodule : lrc_reset_control_props
`default_nettype wire

//--- bench/lrc_mgmt_model.sv
// lrc_mgmt_model: management firmware that reconfigures the phy
// assumes the block's clock and levels
`timescale 1ns/1ns
`default_nettype none
module lrc_mgmt_model #(
  parameter int DELAY = 3 // reconfigure time; raise for slow firmware
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // handshake with the reset block
  input wire logic [lrc_pkg::LRC_NF-1:0] req,
  input wire logic [lrc_pkg::LRC_NF-1:0] phy_rst,
  output logic [lrc_pkg::LRC_NF-1:0] ack
);
  logic [lrc_pkg::LRC_NF-1:0][7:0] cnt_q; // time spent per function
  // phy is only touched once out of reset, then acked once
  always_ff @(posedge clk) begin
    for (int i = 0; i < lrc_pkg::LRC_NF; i++) begin
      cnt_q[i] <= (rst || !req[i] || phy_rst[i]) ? 8'h0 : cnt_q[i] + 8'h1;
      ack[i] <= !rst && req[i] && !phy_rst[i] && cnt_q[i] == 8'(DELAY);
    end
  end
endmodule : lrc_mgmt_model
`default_nettype wire

//--- bench/test_lrc_reset_control.sv
// test_lrc_reset_control: directed bench of the reset block
// assumes package, checker and model compiled first
`timescale 1ns/1ns
`default_nettype none
module test_lrc_reset_control;
  // short counts keep the run brief
  localparam int PC = 4;
  localparam int NL = 8;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic main_ok = 1'b1;
  logic [3:0] cause = 4'h0; // cold exit, message, link down, host drop
  logic [1:0] d3h = 2'h0;
  logic off_n = 1'b1, shut = 1'b0, tgt = 1'b0, tbi = 1'b0;
  logic [2:0] mg = 3'h0; // command, watchdog, asf request
  logic [7:0] mdat = 8'h0;
  logic [1:0][15:0] nvm = '0;
  // bus master side
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] aw = '0, wd = '0, ar = '0;
  logic [3:0] ws = 4'hf;
  // block outputs
  logic chip_rst, host_io, fw_rst, dis, awr, wrdy, bv, arr, rv;
  logic [1:0] func_rst, phy_rst, req, ack, br, rresp;
  logic [31:0] rdat;
  lrc_pkg::lrc_tbi_t tc;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_an = 0;
  lrc_reset_control #(.RST_PULSE_CYC(PC), .NVM_LOAD_CYC(NL)) DUT (
    .MCLK(MCLK), .SRST(SRST), .MAIN_POWER_OK(main_ok), .HOST_POWER_OK(!cause[3]), .PERST_N(1'b1),
    .D3COLD_EXIT(cause[0]), .PCIE_RESET_MSG(cause[1]), .PCIE_LINK_DOWN(cause[2]), .D3HOT_TO_D0(d3h),
    .DEVICE_OFF_N(off_n), .SHUTDOWN(shut), .MGMT_CMD_VALID(mg[0]), .MGMT_CMD_DATA(mdat),
    .MGMT_TARGET(tgt), .ASF_WDOG_EXPIRE(mg[1]), .ASF_FORCE_REQ(mg[2]), .MGMT_PHY_CFG_ACK(ack),
    .NVM_WORD(nvm), .TBI_MODE(tbi), .CHIP_RST(chip_rst), .HOST_IO_RST(host_io), .FUNC_RST(func_rst),
    .PHY_RST(phy_rst), .FW_RST(fw_rst), .DEVICE_DISABLE(dis), .MGMT_PHY_RECONFIG_REQ(req), .TBI_CTRL(tc),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aw), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp));
  lrc_mgmt_model u_mgmt (.clk(MCLK), .rst(SRST), .req(req), .phy_rst(phy_rst), .ack(ack));
  always #2 MCLK = ~MCLK;
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard; also counts function 0's one-cycle restart pulses
  always @(posedge MCLK) begin
    cyc++;
    if (tc.an_restart[0] === 1'b1) n_an++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one write; returns settled just after the response edge
  task automatic wrc(input logic [31:0] a, d, logic [1:0] e);
    @(posedge MCLK);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge MCLK);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    chk(32'(br), 32'(e));
    bre <= 1'b0;
    #1;
  endtask : wrc
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge MCLK);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    rre <= 1'b0;
    #1;
  endtask : rd
  task automatic rdc(input logic [31:0] a, m, e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask : rdc
  // poll config done of one function window
  task automatic wait_done(input logic [31:0] f);
    logic [31:0] d;
    do rd(f + 32'h1010, d);
    while (d[18] !== 1'b1);
  endtask : wait_done
  task automatic t_regs;
    wait_done(32'h0);
    rdc(32'h0000, 32'hffff_ffff, 32'h0);
    rdc(32'h5b50, 32'h1, 32'h0);
    rdc(32'h8f00, 32'h1, 32'h0);
    wrc(32'h0100, 32'h1, 2'h2);
    rdc(32'h0200, 32'hffff_ffff, 32'h0);
    wrc(32'h2_0000, 32'h1, 2'h2);
  endtask : t_regs
  // software phy reset sequence with a partial strobe first
  task automatic t_phy;
    wrc(32'h5b50, 32'h1, 2'h0);
    rdc(32'h5b50, 32'h1, 32'h1);
    @(posedge MCLK);
    ws <= 4'h7;
    wrc(32'h0000, 32'h8000_0000, 2'h0);
    chk(32'(phy_rst), 32'h0);
    ws <= 4'hf;
    wrc(32'h0000, 32'h8000_0000, 2'h0);
    chk(32'(phy_rst), 32'h1);
    rdc(32'h1010, 32'h4_0000, 32'h0);
    repeat (25000) @(posedge MCLK);
    wrc(32'h0000, 32'h0, 2'h0);
    chk(32'({phy_rst, req}), 32'h1);
    wait_done(32'h0);
    chk(32'(req), 32'h0);
    wrc(32'h5b50, 32'h0, 2'h0);
  endtask : t_phy
  // chip-wide causes, one by one
  task automatic t_causes;
    for (int i = 0; i < 4; i++) begin
      wrc(32'h5b50, 32'h1, 2'h0);
      @(posedge MCLK);
      cause <= 4'h1 << i;
      @(posedge MCLK);
      cause <= 4'h0;
      #1;
      if (i == 3) chk(32'(host_io), 32'h1);
      @(posedge MCLK);
      #1;
      chk(32'({chip_rst, func_rst}), 32'h7);
      wait_done(32'h0);
      rdc(32'h5b50, 32'h1, 32'h0);
    end
  endtask : t_causes
  // function scoped resets and nvm reloads
  task automatic t_func;
    wrc(32'h0044, 32'h300, 2'h0);
    wrc(32'h0000, 32'h2, 2'h0);
    wrc(32'h1_0000, 32'h2, 2'h0);
    @(posedge MCLK);
    nvm <= {16'hc3a5, 16'h5a0f};
    wrc(32'h1_0000, 32'h1, 2'h0);
    chk(32'({chip_rst, func_rst}), 32'h2);
    wait_done(32'h1_0000);
    rdc(32'h1_1010, 32'hffff, 32'hc3a5);
    rdc(32'h1_0000, 32'h2, 32'h0);
    rdc(32'h0000, 32'h2, 32'h2);
    rdc(32'h0044, 32'hffff_ffff, 32'h300);
    @(posedge MCLK);
    d3h <= 2'h1;
    @(posedge MCLK);
    d3h <= 2'h0;
    #1;
    chk(32'({chip_rst, func_rst}), 32'h1);
    wait_done(32'h0);
    @(posedge MCLK);
    nvm[0] <= 16'h96e1;
    wrc(32'h0018, 32'h1, 2'h0);
    chk(32'(func_rst), 32'h0);
    wait_done(32'h0);
    rdc(32'h1010, 32'hffff, 32'h96e1);
  endtask : t_func
  task automatic fm(input logic [31:0] c, int k, logic t, logic [7:0] dt, logic [1:0] e);
    wrc(32'h0044, c, 2'h0);
    @(posedge MCLK);
    tgt <= t;
    mdat <= dt;
    mg <= 3'h1 << k;
    @(posedge MCLK);
    mg <= 3'h0;
    #1;
    chk(32'({chip_rst, func_rst}), 32'(e));
    if (e != 2'h0) wait_done(t ? 32'h1_0000 : 32'h0);
  endtask : fm
  task automatic t_forced;
    fm(32'h306, 0, 1'b1, 8'h1, 2'h0);
    fm(32'h305, 0, 1'b1, 8'h1, 2'h0);
    fm(32'h207, 0, 1'b1, 8'h1, 2'h2);
    fm(32'h207, 0, 1'b0, 8'h1, 2'h0);
    fm(32'h307, 0, 1'b0, 8'h2, 2'h0);
    fm(32'h303, 1, 1'b0, 8'h0, 2'h1);
    fm(32'h303, 2, 1'b1, 8'h0, 2'h2);
  endtask : t_forced
  task automatic t_tbi;
    @(posedge MCLK);
    tbi <= 1'b1;
    wrc(32'h0000, 32'h2, 2'h0);
    chk(32'({tc.link_rst[0], tc.send_cfg[0], tc.an_en[0]}), 32'h6);
    wrc(32'h0000, 32'h0, 2'h0);
    chk(32'({n_an == 1, tc.an_en[0]}), 32'h3);
    tbi <= 1'b0;
    wrc(32'h0000, 32'h2, 2'h0);
    chk(32'(tc.link_rst[0]), 32'h0);
  endtask : t_tbi
  // firmware pulse, disable mode, main power loss
  task automatic t_misc;
    wrc(32'h8f00, 32'h1, 2'h0);
    chk(32'(fw_rst), 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      off_n <= i[0];
      shut <= i[1];
      @(posedge MCLK);
      #1;
      chk(32'(dis), 32'(i == 0));
    end
    @(posedge MCLK);
    main_ok <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chk(32'({chip_rst, host_io, func_rst, phy_rst}), 32'h3c);
    @(posedge MCLK);
    main_ok <= 1'b1;
    wait_done(32'h0);
    rdc(32'h0044, 32'hffff_ffff, 32'h0);
  endtask : t_misc
  initial begin
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
    t_regs();
    t_phy();
    t_causes();
    t_func();
    t_forced();
    t_tbi();
    t_misc();
    tally_and_finish();
  end
endmodule : test_lrc_reset_control
bind lrc_reset_control lrc_reset_control_props #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_props (
  .MCLK, .SRST, .MAIN_POWER_OK, .HOST_POWER_OK, .D3COLD_EXIT, .PCIE_RESET_MSG, .PCIE_LINK_DOWN, .D3HOT_TO_D0,
  .DEVICE_OFF_N, .SHUTDOWN, .CHIP_RST, .HOST_IO_RST, .FUNC_RST, .PHY_RST, .FW_RST, .DEVICE_DISABLE,
  .MGMT_PHY_RECONFIG_REQ, .TBI_CTRL);
`default_nettype wire
